// ### ipr_pkg.sv
/*
 * shared constants of the interrupt priority block: register indices,
 * field positions, reset values and the source-to-field map.
 * assumes a 16-bit register port and word indices on the address.
 */
package ipr_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_SRC  = 20;
    localparam int LVL_W    = 3;
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 4;
    localparam int IDX_W    = 5;
    localparam int VEC_W    = 7;
    localparam int CPU_LW   = 4;
    localparam int NUM_EV   = 2;

    // ----------------------------------------------------------------
    // register indices
    // ----------------------------------------------------------------
    localparam logic [3:0] REG_ADC_HI    = 4'h0;
    localparam logic [3:0] REG_PWM_LOW   = 4'h1;
    localparam logic [3:0] REG_PWM_MID   = 4'h2;
    localparam logic [3:0] REG_PWM_HI    = 4'h3;
    localparam logic [3:0] REG_ADC_FIRST = 4'h4;
    localparam logic [3:0] REG_ADC_SEC   = 4'h5;
    localparam logic [3:0] REG_ADC_THIRD = 4'h6;
    localparam logic [3:0] REG_STATUS    = 4'h7;
    localparam logic [3:0] REG_EV_STAT   = 4'h8;
    localparam logic [3:0] REG_EV_CLR    = 4'h9;
    localparam logic [3:0] REG_EV_EN     = 4'hA;

    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam logic [2:0]  LVL_RST     = 3'h4;
    localparam logic [2:0]  LVL_OFF     = 3'h0;
    localparam int          ST_LVL_POS  = 8;
    localparam int          ST_VEC_POS  = 0;
    localparam logic [6:0]  VEC_BASE    = 7'h10; // arbitrary vector of source 0
    localparam int          EV_PRESENT  = 0;
    localparam int          EV_CHANGE   = 1;

    // source order: 0-7 adc pair0..7, 8 adc pair11, 9 adc pair12,
    // 10-18 pwm gen1..9, 19 comparator2
    localparam logic [3:0] SRC_REG [NUM_SRC] = '{
        REG_ADC_FIRST, REG_ADC_FIRST, REG_ADC_SEC, REG_ADC_SEC,
        REG_ADC_SEC, REG_ADC_SEC, REG_ADC_THIRD, REG_ADC_THIRD,
        REG_ADC_HI, REG_ADC_HI,
        REG_PWM_LOW, REG_PWM_LOW, REG_PWM_MID, REG_PWM_MID,
        REG_PWM_MID, REG_PWM_MID, REG_PWM_HI, REG_PWM_HI, REG_PWM_HI,
        REG_PWM_HI};
    localparam int SRC_POS [NUM_SRC] = '{
        8, 12, 0, 4, 8, 12, 0, 4,
        0, 4,
        8, 12, 0, 4, 8, 12, 0, 4, 8,
        12};

endpackage

// ### ipr_pick.sv
/*
 * combinational selection of the most urgent pending source.
 * assumes levels are packed three bits per source, source 0 lowest.
 */
module ipr_pick #(
    parameter int N  = 20,
    parameter int LW = 3,
    parameter int IW = 5
) (
    input  logic [N-1:0]    i_pend,
    input  logic [N*LW-1:0] i_lvl,
    output logic [IW-1:0]   o_idx,
    output logic [LW-1:0]   o_lvl,
    output logic            o_any
);

    // ----------------------------------------------------------------
    // scan
    // ----------------------------------------------------------------
    // strict greater-than keeps the lowest index on equal levels
    always_comb
    begin
        o_idx = '0;
        o_lvl = '0;
        o_any = 1'b0;
        for (int k = 0; k < N; k++)
        begin
            if (i_pend[k] && (i_lvl[k*LW +: LW] > o_lvl))
            begin
                o_idx = IW'(k);
                o_lvl = i_lvl[k*LW +: LW];
                o_any = 1'b1;
            end
        end
    end

endmodule

// ### ipr_top.sv
/*
 * interrupt priority registers with pending-source selection and a
 * status word giving the new cpu level and pending vector index.
 * assumes pending requests come from logic on the same clock, already
 * gated by their flag and enable; register port reads return one
 * cycle after the read strobe.
 */
// Chosen here: strobed register access and the placing of the registers.

// How it works
// - three-bit field gives levels one to seven
// - zero field disables source, never presented
// - unimplemented bits ignore writes, read zero
// - priority fields reset to binary one-zero-zero
// - pwm gen two/one at 14:12, 10:8
// - adc pair seven/six at 6:4, 2:0
// - status bits 11:8 show new cpu level
// - status bits 6:0 show pending vector index
// - every source starts at level four
module ipr_top (
    input  logic                       I_CORE_CLK,
    input  logic                       I_ARST_N,
    input  logic [ipr_pkg::ADDR_W-1:0] I_ADDR,
    input  logic [ipr_pkg::DATA_W-1:0] I_WDATA,
    input  logic                       I_WR,
    input  logic                       I_RD,
    input  logic [ipr_pkg::NUM_SRC-1:0] I_SRC_PEND,
    output logic [ipr_pkg::DATA_W-1:0] O_RDATA,
    output logic [ipr_pkg::CPU_LW-1:0] O_NEW_LEVEL,
    output logic [ipr_pkg::VEC_W-1:0]  O_VECTOR,
    output logic                       O_REQ_VALID,
    output logic                       O_INT
);

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [ipr_pkg::LVL_W-1:0]         lvl_q [ipr_pkg::NUM_SRC];
    logic [ipr_pkg::NUM_SRC*ipr_pkg::LVL_W-1:0] lvl_flat;
    logic [ipr_pkg::IDX_W-1:0]         pick_idx;
    logic [ipr_pkg::LVL_W-1:0]         pick_lvl;
    logic                              pick_any;
    logic [ipr_pkg::IDX_W-1:0]         win_idx_q;
    logic [ipr_pkg::NUM_EV-1:0]        ev_stat_q;
    logic [ipr_pkg::NUM_EV-1:0]        ev_en_q;
    logic [ipr_pkg::NUM_EV-1:0]        ev_en_d;
    logic [ipr_pkg::NUM_EV-1:0]        ev_set;
    logic [ipr_pkg::NUM_EV-1:0]        ev_clr;
    logic [ipr_pkg::DATA_W-1:0]        rdata_d;
    logic [ipr_pkg::DATA_W-1:0]        field_rd;
    logic [ipr_pkg::VEC_W-1:0]         vec_d;
    logic                              first_q;

    // ----------------------------------------------------------------
    // priority fields
    // ----------------------------------------------------------------
    // only the listed field slices are stored, so any other bit of a
    // write simply has nowhere to go
    for (genvar g = 0; g < ipr_pkg::NUM_SRC; g++)
    begin : g_src
        always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
        begin
            if (!I_ARST_N)
                lvl_q[g] <= ipr_pkg::LVL_RST;
            else if (I_WR && (I_ADDR == ipr_pkg::SRC_REG[g]))
                lvl_q[g] <= I_WDATA[ipr_pkg::SRC_POS[g] +: ipr_pkg::LVL_W];
        end
        assign lvl_flat[g*ipr_pkg::LVL_W +: ipr_pkg::LVL_W] = lvl_q[g];
    end

    // ----------------------------------------------------------------
    // selection
    // ----------------------------------------------------------------
    ipr_pick #(
        .N  (ipr_pkg::NUM_SRC),
        .LW (ipr_pkg::LVL_W),
        .IW (ipr_pkg::IDX_W)
    ) u_pick (
        .i_pend (I_SRC_PEND),
        .i_lvl  (lvl_flat),
        .o_idx  (pick_idx),
        .o_lvl  (pick_lvl),
        .o_any  (pick_any)
    );

    assign vec_d = ipr_pkg::VEC_BASE + ipr_pkg::VEC_W'(pick_idx);

    // one cycle from a pending change to the presented answer
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            O_REQ_VALID <= 1'b0;
            O_NEW_LEVEL <= '0;
            O_VECTOR    <= '0;
            win_idx_q   <= '0;
        end
        else
        begin
            O_REQ_VALID <= pick_any;
            O_NEW_LEVEL <= {1'b0, pick_lvl};
            O_VECTOR    <= pick_any ? vec_d : '0;
            win_idx_q   <= pick_idx;
        end
    end

    // ----------------------------------------------------------------
    // events
    // ----------------------------------------------------------------
    assign ev_set[ipr_pkg::EV_PRESENT] = pick_any && !O_REQ_VALID;
    assign ev_set[ipr_pkg::EV_CHANGE]  = pick_any && O_REQ_VALID && (vec_d != O_VECTOR);
    assign ev_clr = (I_WR && (I_ADDR == ipr_pkg::REG_EV_CLR)) ?
                    I_WDATA[ipr_pkg::NUM_EV-1:0] : '0;

    // a set in the clearing cycle wins so no event is lost
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            ev_stat_q <= '0;
        else
            ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
    end

    // the new enable feeds the interrupt in the same edge, so the line
    // never lags the enable register by a cycle
    assign ev_en_d = (I_WR && (I_ADDR == ipr_pkg::REG_EV_EN)) ?
                     I_WDATA[ipr_pkg::NUM_EV-1:0] : ev_en_q;

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            ev_en_q <= '0;
        else
            ev_en_q <= ev_en_d;
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            O_INT <= 1'b0;
        else
            O_INT <= |(((ev_stat_q & ~ev_clr) | ev_set) & ev_en_d);
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always_comb
    begin
        field_rd = '0;
        for (int k = 0; k < ipr_pkg::NUM_SRC; k++)
        begin
            if (I_ADDR == ipr_pkg::SRC_REG[k])
                field_rd[ipr_pkg::SRC_POS[k] +: ipr_pkg::LVL_W] = lvl_q[k];
        end
    end

    // unmapped and write-only addresses read as zero
    always_comb
    begin
        rdata_d = '0;
        if (I_ADDR <= ipr_pkg::REG_ADC_THIRD)
            rdata_d = field_rd;
        else if (I_ADDR == ipr_pkg::REG_STATUS)
        begin
            rdata_d[ipr_pkg::ST_LVL_POS +: ipr_pkg::CPU_LW] = O_NEW_LEVEL;
            rdata_d[ipr_pkg::ST_VEC_POS +: ipr_pkg::VEC_W]  = O_VECTOR;
        end
        else if (I_ADDR == ipr_pkg::REG_EV_STAT)
            rdata_d[ipr_pkg::NUM_EV-1:0] = ev_stat_q;
        else if (I_ADDR == ipr_pkg::REG_EV_EN)
            rdata_d[ipr_pkg::NUM_EV-1:0] = ev_en_q;
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            O_RDATA <= '0;
        else if (I_RD)
            O_RDATA <= rdata_d;
        else
            O_RDATA <= '0;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
            first_q <= 1'b0;
        else
            first_q <= 1'b1;
    end

    AST_RESET_LOW_SRC: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        !first_q |-> lvl_q[0] == 3'h4)
        else $error("source 0 level not 100 after reset");

    AST_RESET_HIGH_SRC: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        !first_q |-> (lvl_q[19] == 3'h4) && (lvl_q[10] == 3'h4))
        else $error("source not at level four after reset");

    AST_NEVER_LEVEL_ZERO: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        O_REQ_VALID |-> (O_NEW_LEVEL != 4'h0) && ($past(lvl_q[pick_idx]) != 3'h0))
        else $error("disabled source presented");

    AST_IDLE_WHEN_NONE: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        (I_SRC_PEND == '0) |=> !O_REQ_VALID ##0 (O_VECTOR == 7'h00))
        else $error("request presented with nothing pending");

    AST_TOP_LEVEL: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        (I_SRC_PEND[19] && lvl_q[19] == 3'h7) |=> O_REQ_VALID
            && (O_NEW_LEVEL == 4'h7))
        else $error("level seven source not presented");

    AST_TIE_LOW_INDEX: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        (I_SRC_PEND[0] && (lvl_q[0] == 3'h7)) |=> (O_VECTOR == ipr_pkg::VEC_BASE))
        else $error("tie not broken toward lowest vector");

    AST_VECTOR_MAP: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        O_REQ_VALID |-> O_VECTOR == ipr_pkg::VEC_BASE + 7'(win_idx_q))
        else $error("vector index does not match winner");

    AST_PWM_LOW_FIELDS: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        (I_RD && I_ADDR == ipr_pkg::REG_PWM_LOW) |=>
            O_RDATA == {1'b0, $past(lvl_q[11]), 1'b0, $past(lvl_q[10]), 8'h00})
        else $error("pwm gen field readback wrong");

    AST_ADC_HI_FIELDS: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        (I_RD && I_ADDR == ipr_pkg::REG_ADC_HI) |=>
            O_RDATA == {9'h000, $past(lvl_q[9]), 1'b0, $past(lvl_q[8])})
        else $error("adc pair field readback wrong");

    AST_STATUS_READ: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        (I_RD && I_ADDR == ipr_pkg::REG_STATUS) |=>
            (O_RDATA[11:8] == $past(O_NEW_LEVEL)) && (O_RDATA[15:12] == 4'h0)
            && (O_RDATA[7] == 1'b0) && (O_RDATA[6:0] == $past(O_VECTOR)))
        else $error("status word wrong");

    AST_LEVEL_RANGE: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        O_REQ_VALID |-> (O_NEW_LEVEL >= 4'h1) && (O_NEW_LEVEL <= 4'h7))
        else $error("presented level out of one to seven");

    AST_RESET_ALL_SRC: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        !first_q |-> (lvl_flat == {ipr_pkg::NUM_SRC{ipr_pkg::LVL_RST}}))
        else $error("a level field left reset other than 100");

    AST_IDLE_OUTPUTS_ZERO: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        !O_REQ_VALID |-> (O_NEW_LEVEL == 4'h0) && (O_VECTOR == 7'h00))
        else $error("level or vector shown with no request");

    AST_DISABLED_ALONE: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        (I_SRC_PEND[0] && (I_SRC_PEND[ipr_pkg::NUM_SRC-1:1] == '0)
            && (lvl_q[0] == 3'h0)) |=> !O_REQ_VALID)
        else $error("disabled source presented alone");

    AST_WINNER_PENDING: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        O_REQ_VALID |-> $past(I_SRC_PEND[pick_idx]))
        else $error("presented source was not pending");

    AST_WINNER_LEVEL: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        O_REQ_VALID |-> (O_NEW_LEVEL == {1'b0, $past(lvl_q[pick_idx])}))
        else $error("presented level differs from winner field");

    AST_RDATA_IDLE: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        !$past(I_RD) |-> (O_RDATA == 16'h0000))
        else $error("read data shown without a read");

    AST_READ_UNMAPPED: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        (I_RD && (I_ADDR > ipr_pkg::REG_EV_EN)) |=> (O_RDATA == 16'h0000))
        else $error("unmapped index read not zero");

    AST_READ_CLEAR_REG: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        (I_RD && (I_ADDR == ipr_pkg::REG_EV_CLR)) |=> (O_RDATA == 16'h0000))
        else $error("write-only clear register read not zero");

    AST_FOUR_FIELD_GAPS: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        (I_RD && ((I_ADDR == ipr_pkg::REG_PWM_MID) || (I_ADDR == ipr_pkg::REG_PWM_HI)
            || (I_ADDR == ipr_pkg::REG_ADC_SEC))) |=> ((O_RDATA & 16'h8888) == 16'h0000))
        else $error("gap bit of a four-field register not zero");

    AST_ADC_FIRST_GAPS: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        (I_RD && (I_ADDR == ipr_pkg::REG_ADC_FIRST)) |=> ((O_RDATA & 16'h88FF) == 16'h0000))
        else $error("gap bit of adc pair register not zero");

    AST_ADC_THIRD_FIELDS: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        (I_RD && (I_ADDR == ipr_pkg::REG_ADC_THIRD)) |=>
            O_RDATA == {9'h000, $past(lvl_q[7]), 1'b0, $past(lvl_q[6])})
        else $error("adc pair seven/six readback wrong");

    AST_PWM_LOW_WRITE: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        (I_WR && (I_ADDR == ipr_pkg::REG_PWM_LOW)) |=>
            (lvl_q[10] == $past(I_WDATA[10:8])) && (lvl_q[11] == $past(I_WDATA[14:12])))
        else $error("pwm gen field not taken from its bits");

    AST_ADC_HI_WRITE: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        (I_WR && (I_ADDR == ipr_pkg::REG_ADC_HI)) |=>
            (lvl_q[8] == $past(I_WDATA[2:0])) && (lvl_q[9] == $past(I_WDATA[6:4])))
        else $error("adc pair field not taken from its bits");

    AST_OTHER_WRITE_IGNORED: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        (!I_WR || (I_ADDR > ipr_pkg::REG_ADC_THIRD)) |=> $stable(lvl_flat))
        else $error("level field changed without a write to it");

    AST_INT_FOLLOWS_STATUS: assert property (
        @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
        O_INT == |(ev_stat_q & ev_en_q))
        else $error("interrupt line not equal to enabled status");

endmodule

// ### ipr_cpu_model.sv
/*
 * behavioural cpu side: takes each presented request, keeps the last
 * vector taken and counts new presentations.
 * assumes the block's outputs are registered on the same clock.
 */
module ipr_cpu_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_valid,
    input  wire logic [3:0] i_level,
    input  wire logic [6:0] i_vector,
    output logic [6:0]      o_last_vec,
    output logic [7:0]      o_takes
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // acceptance
    // ----------------------------------------------------------------
    logic valid_q;

    // only a rising request counts, a held one is the same request
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            valid_q    <= 1'b0;
            o_last_vec <= 7'h00;
            o_takes    <= 8'h00;
        end
        else
        begin
            valid_q <= i_valid;
            if (i_valid && i_level != 4'h0)
                o_last_vec <= i_vector;
            if (i_valid && !valid_q)
                o_takes <= o_takes + 8'h01;
        end
    end
endmodule

// ### testbench.sv
/*
 * self-checking bench: register port, source selection, status word
 * and event interrupt.
 * assumes the package, the design and the cpu model are compiled first.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [3:0]  addr  = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic [19:0] pend  = 20'h00000;
    logic [15:0] rdata;
    logic [3:0]  lvl;
    logic [6:0]  vec;
    logic        valid;
    logic        irq;
    logic [6:0]  last_vec;
    logic [7:0]  takes;
    logic [15:0] v;
    int          n_mismatch   = 0;
    int          total_checks = 0;
    // implemented field bits of indices 0..6
    localparam logic [15:0] FULL [7] = '{16'h0077, 16'h7700, 16'h7777, 16'h7777,
                                         16'h7700, 16'h7777, 16'h0077};

    always #10 clk = ~clk;

    ipr_top ipr_top_i (.I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .I_SRC_PEND(pend), .O_RDATA(rdata), .O_NEW_LEVEL(lvl),
        .O_VECTOR(vec), .O_REQ_VALID(valid), .O_INT(irq));
    ipr_cpu_model ipr_cpu_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_valid(valid),
        .i_level(lvl), .i_vector(vec), .o_last_vec(last_vec), .o_takes(takes));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask

    task automatic read_chk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        read_reg(a, d);
        check(d, exp, "register read");
    endtask

    // packed as {4'h0, valid, level[2:0], level[3], vector}; level[3] must stay 0
    task automatic present(input logic [19:0] p, input logic [15:0] exp);
        pend <= p;
        @(posedge clk);
        @(negedge clk);
        check({4'h0, valid, lvl[2:0], lvl[3], vec}, exp, "presented request");
        @(posedge clk);
    endtask

    task automatic int_is(input logic exp);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({15'h0000, irq}, {15'h0000, exp}, "interrupt line");
        @(posedge clk);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int r = 0; r < 7; r++)
            read_chk(4'(r), FULL[r] & 16'h4444);
        read_chk(4'h7, 16'h0000);
        read_chk(4'h9, 16'h0000);
        for (int r = 11; r < 16; r++)
            read_chk(4'(r), 16'h0000);
        for (int r = 0; r < 16; r++)
            write_reg(4'(r), 16'hFFFF);
        for (int r = 0; r < 7; r++)
            read_chk(4'(r), FULL[r]);
        read_chk(4'h7, 16'h0000);
        read_chk(4'hB, 16'h0000);
        write_reg(4'h9, 16'h0003);
        $display("test registers done");
        // every level now 7: equal levels go to the lower source
        present(20'h80008, 16'h0F13);
        write_reg(4'h4, 16'h0000);
        present(20'h00001, 16'h0000);
        present(20'h80001, 16'h0F23);
        write_reg(4'h3, 16'h1000);
        present(20'h80000, 16'h0923);
        read_chk(4'h7, 16'h0123);
        present(20'h80400, 16'h0F1A);
        read_chk(4'h7, 16'h071A);
        $display("test selection done");
        present(20'h00000, 16'h0000);
        write_reg(4'h9, 16'h0003);
        write_reg(4'hA, 16'h0000);
        present(20'h80000, 16'h0923);
        read_chk(4'h8, 16'h0001);
        int_is(1'b0);
        write_reg(4'hA, 16'h0001);
        int_is(1'b1);
        read_chk(4'hA, 16'h0001);
        write_reg(4'h9, 16'h0001);
        int_is(1'b0);
        read_chk(4'h8, 16'h0000);
        write_reg(4'hA, 16'h0003);
        present(20'h80400, 16'h0F1A);
        read_chk(4'h8, 16'h0002);
        int_is(1'b1);
        check({8'h00, takes}, 16'h0003, "cpu takes");
        check({9'h000, last_vec}, 16'h001A, "cpu vector");
        $display("test events done");
        complete_run();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
endmodule
